// ===== rtl/sdbg_device.sv
`timescale 1ns/10ps
`default_nettype none
module sdbg_device
	import sdbg_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Link
	sdbg_if.device link,
	// Mode and bus arbitration
	input wire logic i_instr_enable,
	input wire logic i_bus_grant_enable,
	input wire logic i_external_bus_request,
	output logic o_external_bus_grant,
	// Register space access
	output logic [6:0] o_reg_addr,
	output logic [7:0] o_wr_data,
	output logic o_wr_strobe,
	output logic o_rd_strobe,
	input wire logic [7:0] i_rd_data,
	output logic o_active
);
	// Only disabling the port returns it to idle; a start restarts framing
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CMD,
		ST_WRITE,
		ST_READ
	} phase_e;

	typedef struct packed {
		logic [1:0] clk_sync;
		logic [1:0] dat_sync;
		logic [1:0] req_sync;
		logic clk_prev;
		logic dat_prev;
		phase_e phase;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [6:0] addr;
		logic first_byte;
		logic sep_high;
		logic grant;
		logic drv;
		logic drv_oe;
		logic [7:0] wr_data;
		logic wr_strobe;
		logic rd_strobe;
	} state_s;

	state_s state_reg;
	state_s state_next;
	logic clk_s;
	logic dat_s;
	logic req_s;
	logic clk_rise;
	logic clk_fall;
	logic start_seen;
	logic port_on;

	assign clk_s = state_reg.clk_sync[1];
	assign dat_s = state_reg.dat_sync[1];
	// The request comes from another master's pin, so it is synchronised too
	assign req_s = state_reg.req_sync[1];
	// Edges come only from synchronised copies, never the raw pins
	assign clk_rise = clk_s && !state_reg.clk_prev;
	assign clk_fall = !clk_s && state_reg.clk_prev;
	// A data rise with clock high is simply not decoded
	assign start_seen = clk_s && state_reg.clk_prev && state_reg.dat_prev && !dat_s;
	assign port_on = !i_instr_enable;

	always_comb begin
		state_next = state_reg;
		state_next.clk_sync = {state_reg.clk_sync[0], link.debug_serial_clock};
		state_next.dat_sync = {state_reg.dat_sync[0], link.debug_serial_data};
		state_next.req_sync = {state_reg.req_sync[0], i_external_bus_request};
		state_next.clk_prev = clk_s;
		state_next.dat_prev = dat_s;
		state_next.wr_strobe = 1'b0;
		state_next.rd_strobe = 1'b0;
		if (!port_on) begin
			state_next.phase = ST_IDLE;
			state_next.drv_oe = 1'b0;
			state_next.sep_high = 1'b1;
		end else if (start_seen) begin
			// A start aborts anything in progress
			state_next.phase = ST_CMD;
			state_next.bit_cnt = BIT_FIRST;
			state_next.drv_oe = 1'b0;
			state_next.first_byte = 1'b1;
			state_next.sep_high = 1'b0;
		end else if (clk_rise && state_reg.phase != ST_IDLE) begin
			if (state_reg.bit_cnt == BIT_SEPARATOR) begin
				state_next.bit_cnt = BIT_FIRST;
				state_next.sep_high = dat_s;
				case (state_reg.phase)
					ST_CMD: begin
						// Shift holds address and direction bit
						state_next.addr = state_reg.shift[7:1];
						state_next.phase = (state_reg.shift[0] == DIR_READ) ? ST_READ : ST_WRITE;
						state_next.first_byte = 1'b1;
						if (state_reg.shift[0] == DIR_READ) begin
							state_next.rd_strobe = 1'b1;
						end
					end
					ST_WRITE: begin
						state_next.wr_data = state_reg.shift;
						state_next.wr_strobe = 1'b1;
						state_next.first_byte = 1'b0;
					end
					ST_READ: begin
						state_next.rd_strobe = 1'b1;
						state_next.first_byte = 1'b0;
					end
					default: begin
						state_next.phase = ST_IDLE;
					end
				endcase
			end else begin
				if (state_reg.phase != ST_READ) begin
					state_next.shift = {state_reg.shift[6:0], dat_s};
				end
				state_next.bit_cnt = state_reg.bit_cnt + CNT_ONE;
			end
		end else if (clk_fall && state_reg.phase == ST_READ) begin
			// Device drives data only during the eight data bits
			if (state_reg.bit_cnt == BIT_FIRST) begin
				state_next.drv = i_rd_data[DATA_W-1];
				state_next.shift = {i_rd_data[6:0], 1'b0};
				state_next.drv_oe = 1'b1;
			end else if (state_reg.bit_cnt <= BIT_LAST_DATA) begin
				state_next.drv = state_reg.shift[7];
				state_next.shift = {state_reg.shift[6:0], 1'b0};
				state_next.drv_oe = 1'b1;
			end else begin
				state_next.drv_oe = 1'b0;
			end
		end
		// Address advance after each byte, stopping at TOP_WR_ADDR for writes and TOP_RD_ADDR for reads
		if (state_reg.wr_strobe && state_reg.addr != TOP_WR_ADDR) begin
			state_next.addr = state_reg.addr + ADDR_ONE;
		end
		if (state_reg.rd_strobe && !state_reg.first_byte && state_reg.addr != TOP_RD_ADDR) begin
			state_next.addr = state_reg.addr + ADDR_ONE;
		end
		// Grant given only between operations and when allowed
		// Once given it holds until request or enable drops, so the other
		// master is never cut off in the middle of its own bus cycle
		if (!i_bus_grant_enable || !req_s) begin
			state_next.grant = 1'b0;
		end else if (state_reg.sep_high || state_reg.phase == ST_IDLE) begin
			state_next.grant = 1'b1;
		end
	end

	// Reset leaves the synchronisers at the idle pin levels, so that no false
	// edge or start follows release
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state_reg <= '0;
			state_reg.clk_sync <= 2'b11;
			state_reg.dat_sync <= 2'b11;
			state_reg.clk_prev <= 1'b1;
			state_reg.dat_prev <= 1'b1;
			state_reg.phase <= ST_IDLE;
			// Reset counts as a completed operation for the grant
			state_reg.sep_high <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign link.data_from_device = state_reg.drv;
	assign link.data_device_oe = state_reg.drv_oe;
	assign o_external_bus_grant = state_reg.grant;
	assign o_reg_addr = state_reg.addr;
	assign o_wr_data = state_reg.wr_data;
	assign o_wr_strobe = state_reg.wr_strobe;
	assign o_rd_strobe = state_reg.rd_strobe;
	assign o_active = (state_reg.phase != ST_IDLE);
endmodule
`default_nettype wire

// ===== rtl/sdbg_pkg.sv
package sdbg_pkg;
	// Register address space
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam logic [6:0] TOP_WR_ADDR = 7'h30;
	localparam logic [6:0] TOP_RD_ADDR = 7'h20;
	// Bits per byte frame: eight data plus separator
	localparam logic [3:0] BIT_LAST_DATA = 4'h7;
	localparam logic [3:0] BIT_SEPARATOR = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	// Direction bit encoding
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	// Timing
	localparam int SYS_CLK_MHZ = 50;
	localparam int LINK_CLK_MHZ = 8;
	localparam int LINK_HALF_CYC = SYS_CLK_MHZ / (2 * LINK_CLK_MHZ);
	localparam int DIV_W = 8;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
	localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [6:0] ADDR_ONE = 7'h01;
endpackage

// ===== rtl/sdbg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sdbg_if;
	// Serial clock, always driven by the master
	logic debug_serial_clock;
	// Data line: driven by master or by device
	logic data_from_master;
	logic data_master_oe;
	logic data_from_device;
	logic data_device_oe;
	logic debug_serial_data;
	// Pulled-up wire resolution
	assign debug_serial_data = data_device_oe ? data_from_device :
		(data_master_oe ? data_from_master : 1'b1);
	modport device (
		input debug_serial_clock,
		input debug_serial_data,
		output data_from_device,
		output data_device_oe
	);
	modport master (
		output debug_serial_clock,
		input debug_serial_data,
		output data_from_master,
		output data_master_oe
	);
endinterface
`default_nettype wire

// ===== rtl/sdbg_master.sv
`timescale 1ns/10ps
`default_nettype none
module sdbg_master
	import sdbg_pkg::*;
#(
	parameter int HALF_CYC = LINK_HALF_CYC
)(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Link
	sdbg_if.master link,
	// Byte request: start flag begins a new command frame
	input wire logic i_valid,
	input wire logic i_start,
	input wire logic i_is_read,
	input wire logic i_separator,
	input wire logic [7:0] i_data,
	output logic o_ready,
	// Byte answer
	output logic o_done,
	output logic [7:0] o_rd_data
);
	typedef enum logic [2:0] {
		M_IDLE,
		M_START,
		M_LOW,
		M_HIGH,
		M_STOP
	} mstate_e;

	typedef struct packed {
		mstate_e st;
		logic [DIV_W-1:0] div;
		logic [3:0] bit_cnt;
		logic [7:0] tx;
		logic [7:0] rx;
		logic is_read;
		logic sep;
		logic scl;
		logic sda;
		logic sda_oe;
		logic [1:0] din_sync;
		logic done;
	} mst_s;

	mst_s m_reg;
	mst_s m_next;
	logic tick;
	logic din;

	assign tick = (m_reg.div == DIV_ZERO);
	assign din = m_reg.din_sync[1];

	always_comb begin
		m_next = m_reg;
		m_next.din_sync = {m_reg.din_sync[0], link.debug_serial_data};
		m_next.done = 1'b0;
		m_next.div = tick ? DIV_ZERO : m_reg.div - DIV_ONE;
		case (m_reg.st)
			M_IDLE: begin
				// Idle with clock held high
				m_next.scl = 1'b1;
				if (i_valid) begin
					m_next.tx = i_data;
					m_next.is_read = i_is_read;
					m_next.sep = i_separator;
					m_next.bit_cnt = CNT_ZERO;
					m_next.div = DIV_W'(HALF_CYC);
					if (i_start) begin
						m_next.sda = 1'b1;
						m_next.sda_oe = 1'b1;
						m_next.st = M_START;
					end else begin
						m_next.st = M_LOW;
						m_next.scl = 1'b0;
					end
				end
			end
			M_START: begin
				if (tick) begin
					// Data falls while clock high
					m_next.sda = 1'b0;
					m_next.st = M_STOP;
					m_next.div = DIV_W'(HALF_CYC);
				end
			end
			M_STOP: begin
				if (tick) begin
					m_next.scl = 1'b0;
					m_next.st = M_LOW;
					m_next.div = DIV_W'(HALF_CYC);
				end
			end
			M_LOW: begin
				// Data moves one cycle before the clock rises, never with it; this
				// matches the far end's synchroniser delay, so HALF_CYC must be >= 1
				if (m_reg.div == DIV_ONE) begin
					if (m_reg.bit_cnt == BIT_SEPARATOR) begin
						m_next.sda = m_reg.sep;
						m_next.sda_oe = 1'b1;
					end else if (m_reg.is_read) begin
						m_next.sda_oe = 1'b0;
					end else begin
						m_next.sda = m_reg.tx[7];
						m_next.sda_oe = 1'b1;
						m_next.tx = {m_reg.tx[6:0], 1'b0};
					end
				end
				if (tick) begin
					m_next.scl = 1'b1;
					m_next.st = M_HIGH;
					m_next.div = DIV_W'(HALF_CYC);
				end
			end
			M_HIGH: begin
				if (tick) begin
					if (m_reg.bit_cnt == BIT_SEPARATOR) begin
						// Stop in ninth cycle with clock high
						m_next.st = M_IDLE;
						m_next.done = 1'b1;
						m_next.rx = m_reg.tx;
					end else begin
						if (m_reg.is_read) begin
							m_next.tx = {m_reg.tx[6:0], din};
						end
						m_next.bit_cnt = m_reg.bit_cnt + CNT_ONE;
						m_next.scl = 1'b0;
						m_next.st = M_LOW;
						m_next.div = DIV_W'(HALF_CYC);
					end
				end
			end
			default: begin
				m_next.st = M_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			m_reg <= '0;
			m_reg.st <= M_IDLE;
			m_reg.scl <= 1'b1;
			m_reg.sda <= 1'b1;
		end else begin
			m_reg <= m_next;
		end
	end

	assign link.debug_serial_clock = m_reg.scl;
	assign link.data_from_master = m_reg.sda;
	assign link.data_master_oe = m_reg.sda_oe;
	assign o_ready = (m_reg.st == M_IDLE);
	assign o_done = m_reg.done;
	assign o_rd_data = m_reg.rx;
endmodule
`default_nettype wire

// ===== testbench/sdbg_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sdbg_properties (
	// System domain
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Link wires
	input wire logic debug_serial_clock,
	input wire logic data_from_device,
	input wire logic data_device_oe,
	input wire logic debug_serial_data
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	logic clk_q, dat_q, sep_reg, start;
	logic [3:0] bit_reg;
	// Raw wire view, so link timing is judged without any synchroniser delay
	assign start = clk_q && debug_serial_clock && dat_q && !debug_serial_data;
	always_ff @(posedge i_clk_sys) begin
		clk_q <= debug_serial_clock;
		dat_q <= debug_serial_data;
		if (i_reset) begin
			sep_reg <= 1'b1;
			bit_reg <= 4'h0;
		end else if (start) begin
			bit_reg <= 4'h0;
		end else if (!clk_q && debug_serial_clock) begin
			bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
			if (bit_reg == 4'h8)
				sep_reg <= debug_serial_data;
		end
	end
	AST_LINK_CLK_HALF: assert property ($changed(debug_serial_clock) |=>
		$stable(debug_serial_clock)) else $error("link clock half period too short");
	AST_START_ON_BYTE: assert property (start |-> bit_reg == 4'h0)
		else $error("start inside a byte frame");
	AST_SEP_BEFORE_START: assert property (start |-> sep_reg)
		else $error("start after low separator");
	AST_NO_DEV_AT_START: assert property (start |-> !data_device_oe)
		else $error("device drives data at start");
	AST_DEV_DATA_CLK_LOW: assert property (data_device_oe && $past(data_device_oe) &&
		$changed(data_from_device) |-> !debug_serial_clock) else $error("device data moved, clock high");
	AST_DEV_OE_ON_LOW: assert property ($rose(data_device_oe) |-> !debug_serial_clock)
		else $error("device began driving with clock high");
	AST_DEV_OFF_NINTH: assert property (bit_reg == 4'h8 && $fell(debug_serial_clock)
		|-> ##[1:8] !data_device_oe) else $error("device drives separator bit");
	AST_CLK_LOW_BOUNDED: assert property (!debug_serial_clock |-> ##[1:8] debug_serial_clock)
		else $error("link clock left low");
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import sdbg_pkg::*;
	logic i_clk_sys, i_reset, instr_en, grant_en, bus_req, grant;
	logic valid, start, is_read, sep, ready, done, wr_stb, rd_stb, active;
	int rd_cnt = 0;
	logic [7:0] data, rd_q, rd_out, wr_data, rd_data;
	logic [6:0] reg_addr;
	logic [14:0] wq[$];
	int miscompares = 0, checks = 0, cycles = 0;
	sdbg_if link();
	sdbg_device u_sdbg_device (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .link(link),
		.i_instr_enable(instr_en), .i_bus_grant_enable(grant_en),
		.i_external_bus_request(bus_req), .o_external_bus_grant(grant), .o_reg_addr(reg_addr),
		.o_wr_data(wr_data), .o_wr_strobe(wr_stb), .o_rd_strobe(rd_stb), .i_rd_data(rd_data),
		.o_active(active));
	sdbg_master u_sdbg_master (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .link(link),
		.i_valid(valid), .i_start(start), .i_is_read(is_read), .i_separator(sep), .i_data(data),
		.o_ready(ready), .o_done(done), .o_rd_data(rd_out));
	sdbg_properties u_sdbg_properties (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.debug_serial_clock(link.debug_serial_clock), .data_from_device(link.data_from_device),
		.data_device_oe(link.data_device_oe), .debug_serial_data(link.debug_serial_data));
	initial begin
		i_clk_sys = 0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	// Read side stand-in: each address answers with a value of its own
	always_comb rd_data = {1'b1, reg_addr};
	always @(posedge i_clk_sys) begin
		cycles++;
		if (wr_stb)
			wq.push_back({reg_addr, wr_data});
		if (rd_stb)
			rd_cnt++;
		if (cycles == 10000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// One byte through the master; entered and left on a rising edge
	task automatic xfer(logic st, logic rd, logic sp, logic [7:0] d);
		int n;
		valid <= 1;
		start <= st;
		is_read <= rd;
		sep <= sp;
		data <= d;
		do @(negedge i_clk_sys); while (ready !== 1'b1);
		@(posedge i_clk_sys);
		valid <= 0;
		n = 0;
		do begin
			@(negedge i_clk_sys);
			n++;
		end while (done !== 1'b1 && n < 400);
		if (done !== 1'b1)
			miscompares++;
		rd_q = rd_out;
		@(posedge i_clk_sys);
	endtask
	// Strobes trail the link by the synchroniser delay
	task automatic settle();
		repeat (16) @(posedge i_clk_sys);
	endtask
	task automatic wchk(logic [6:0] a, logic [7:0] d);
		logic [14:0] e;
		e = 'x;
		if (wq.size() > 0)
			e = wq.pop_front();
		chk("wr addr", {1'b0, a}, {1'b0, e[14:8]});
		chk("wr data", d, e[7:0]);
	endtask
	initial begin
		{i_reset, instr_en, grant_en, bus_req, valid, start, is_read, sep} = 8'h80;
		data = 8'h00;
		repeat (4) @(posedge i_clk_sys);
		i_reset <= 0;
		settle();
		chk("active", 8'h00, {7'h00, active});
		bus_req <= 1;
		xfer(1, 0, 0, {7'h10, 1'b0});
		chk("grant", 8'h00, {7'h00, grant});
		chk("active", 8'h01, {7'h00, active});
		xfer(0, 0, 1, 8'hA5);
		settle();
		wchk(7'h10, 8'hA5);
		$display("single write finished");
		xfer(1, 0, 0, {7'h2F, 1'b0});
		// Enabled after a low separator, so the grant must keep waiting
		grant_en <= 1;
		xfer(0, 0, 0, 8'h11);
		chk("grant", 8'h00, {7'h00, grant});
		xfer(0, 0, 0, 8'h22);
		xfer(0, 0, 1, 8'h33);
		settle();
		chk("grant", 8'h01, {7'h00, grant});
		wchk(7'h2F, 8'h11);
		wchk(7'h30, 8'h22);
		wchk(7'h30, 8'h33);
		bus_req <= 0;
		grant_en <= 0;
		$display("block write finished");
		xfer(1, 0, 0, {7'h00, 1'b1});
		xfer(0, 1, 1, 8'hFF);
		chk("rd data", 8'h80, rd_q);
		settle();
		chk("wr count", 8'h00, 8'(wq.size()));
		chk("rd strobes", 8'h02, 8'(rd_cnt));
		$display("single read finished");
		xfer(1, 0, 0, {7'h1F, 1'b1});
		for (int i = 0; i < 3; i++) begin
			xfer(0, 1, i == 2, 8'hFF);
			chk("rd data", i ? 8'hA0 : 8'h9F, rd_q);
		end
		settle();
		chk("rd strobes", 8'h06, 8'(rd_cnt));
		$display("block read finished");
		instr_en <= 1;
		xfer(1, 0, 0, {7'h05, 1'b0});
		xfer(0, 0, 1, 8'h5A);
		settle();
		chk("wr count", 8'h00, 8'(wq.size()));
		chk("active", 8'h00, {7'h00, active});
		$display("disabled port finished");
		test_done();
	end
endmodule
`default_nettype wire
